/* File: sim/pwm_counter_compare_events_props.sv */
`default_nettype none
module pwm_counter_compare_events_props (
    input wire logic CLK_SYS, RESET_N, PSEL, PENABLE, PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA, PRDATA,
    input wire logic PREADY, PSLVERR, ZERO_PULSE, LIMIT_PULSE,
    input wire logic FIRST_MATCH_PULSE, SECOND_MATCH_PULSE, COUNT_DIR_UP, EVENT_IRQ
);
    wire logic mapped = PADDR == 12'h000 || (PADDR >= 12'h040 && PADDR <= 12'h05C
        && PADDR[1:0] == 2'h0);
    wire logic clr_wr = PSEL && PENABLE && PWRITE && (PADDR == 12'h04C || PADDR == 12'h044);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RESET_N);
    sequence s_xfer; PSEL && !PENABLE ##1 PSEL && PENABLE; endsequence
    property p_ready_time; s_xfer |-> PREADY; endproperty
    a_ready_time: assert property (p_ready_time) else $error("late ready");
    property p_ready_one; PREADY |=> !PREADY; endproperty
    a_ready_one: assert property (p_ready_one) else $error("long ready");
    property p_ready_acc; PREADY |-> PSEL && PENABLE && $past(PSEL && !PENABLE); endproperty
    a_ready_acc: assert property (p_ready_acc) else $error("stray ready");
    property p_err_map; PREADY |-> PSLVERR == !mapped; endproperty
    a_err_map: assert property (p_err_map) else $error("bad error flag");
    property p_err_zero; PREADY && PSLVERR && !PWRITE |-> PRDATA == 32'h0; endproperty
    a_err_zero: assert property (p_err_zero) else $error("error read data");
    property p_upper; PREADY && !PWRITE |-> PRDATA[31:16] == 16'h0000; endproperty
    a_upper: assert property (p_upper) else $error("upper bits set");
    property p_rst; $rose(RESET_N) |-> !PREADY && !EVENT_IRQ && !ZERO_PULSE && !LIMIT_PULSE;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs after reset");
    property p_irq_hold; $fell(EVENT_IRQ) |-> $past(clr_wr) || $past(clr_wr, 2); endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq dropped");
endmodule // pwm_counter_compare_events_props
bind pwm_counter_compare_events pwm_counter_compare_events_props u_props (.*);
`default_nettype wire

/* File: sim/pwm_counter_compare_events_tb_top.sv */
`include "pwm_counter_regs.vh"
`default_nettype none
module pwm_counter_compare_events_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, err;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, rdata;
    logic [11:0] ra [8] = '{`ADDR_CONTROL, `ADDR_ENABLE_MASK, `ADDR_MASKED_STATUS, `ADDR_LIMIT,
        `ADDR_COUNT, `ADDR_CMP_FIRST, `ADDR_CMP_SECOND, `ADDR_SYNC_REQ};
    wire logic [31:0] prdata;
    wire logic pready, pslverr, zp, lp, fp, sp, dir, irq, irq_seen;
    int error_cnt = 0, n_checks = 0, cyc = 0, per;
    int nl, nf, ns, nd;
    initial forever #25 clk_sys = ~clk_sys;
    pwm_counter_compare_events u_pwm_counter_compare_events (.CLK_SYS(clk_sys),
        .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .ZERO_PULSE(zp), .LIMIT_PULSE(lp), .FIRST_MATCH_PULSE(fp),
        .SECOND_MATCH_PULSE(sp), .COUNT_DIR_UP(dir), .EVENT_IRQ(irq));
    pwm_irq_sink u_pwm_irq_sink (.CLK_SYS(clk_sys), .RESET_N(reset_n), .EVENT_IRQ(irq),
        .IRQ_SEEN(irq_seen));
    task test_done;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // Reserved upper bits are always written as zero.
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d); apb(1'b1, a, d); endtask
    task rd(input logic [11:0] a, input logic [31:0] e); apb(1'b0, a, 32'h0); chk(rdata, e);
    endtask
    // Cycles between two zero pulses, measured twice so a pending update has landed.
    task per_m;
        repeat (2) begin
            @(posedge clk_sys);
            while (zp !== 1'b1) @(posedge clk_sys);
            per = 0;
            nl = 0;
            nf = 0;
            ns = 0;
            nd = 0;
            do begin
                @(posedge clk_sys);
                per++;
                nl += (lp === 1'b1);
                nf += (fp === 1'b1);
                ns += (sp === 1'b1);
                nd += (dir === 1'b1);
            end while (zp !== 1'b1);
        end
    endtask
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            test_done;
        end
    end
    initial begin
        repeat (10) @(posedge clk_sys);
        reset_n <= 1'b1;
        for (int i = 0; i < 8; i++) rd(ra[i], 32'h0);
        apb(1'b0, 12'h100, 32'h0); chk(err, 1'b1); chk(rdata, 32'h0);
        wr(`ADDR_LIMIT, 32'h7); rd(`ADDR_LIMIT, 32'h7);
        wr(`ADDR_CMP_FIRST, 32'h3); rd(`ADDR_CMP_FIRST, 32'h3);
        wr(`ADDR_CMP_SECOND, 32'h9); rd(`ADDR_CMP_SECOND, 32'h9);
        per_m; chk(per, 32'd8);
        chk(nl, 32'd1);
        chk(nf, 32'd1);
        chk(ns, 32'd0);
        chk(nd, 32'd0);
        wr(`ADDR_MASKED_STATUS, 32'h3F); per_m; rd(`ADDR_RAW_STATUS, 32'h0B);
        rd(`ADDR_MASKED_STATUS, 32'h0);
        wr(`ADDR_ENABLE_MASK, 32'h8); rd(`ADDR_MASKED_STATUS, 32'h8); chk(irq, 1'b1);
        chk(irq_seen, 1'b1);
        wr(`ADDR_MASKED_STATUS, 32'h0); rd(`ADDR_MASKED_STATUS, 32'h8);
        wr(`ADDR_RAW_STATUS, 32'h3F); rd(`ADDR_RAW_STATUS, 32'h0B);
        $display("down mode test done");
        wr(`ADDR_CONTROL, 32'h2); per_m; chk(per, 32'd14);
        chk(nf, 32'd2);
        chk(nd, 32'd7);
        wr(`ADDR_MASKED_STATUS, 32'h3F); per_m; rd(`ADDR_RAW_STATUS, 32'h0F);
        wr(`ADDR_CONTROL, 32'h2A); wr(`ADDR_LIMIT, 32'h5); wr(`ADDR_LIMIT, 32'h4);
        wr(`ADDR_CMP_SECOND, 32'h2); per_m; chk(per, 32'd14);
        wr(`ADDR_MASKED_STATUS, 32'h3F); per_m; rd(`ADDR_RAW_STATUS, 32'h0F);
        wr(`ADDR_SYNC_REQ, 32'h5); per_m; chk(per, 32'd8);
        chk(nl, 32'd1);
        chk(ns, 32'd2);
        wr(`ADDR_MASKED_STATUS, 32'h3F); per_m; rd(`ADDR_RAW_STATUS, 32'h3F);
        $display("up down test done");
        test_done;
    end
endmodule // pwm_counter_compare_events_tb_top
`default_nettype wire

/* File: sim/pwm_irq_sink.sv */
`default_nettype none
module pwm_irq_sink (
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    input wire logic EVENT_IRQ,
    output var logic IRQ_SEEN
);
    timeunit 1ns;
    timeprecision 1ns;
    // Sticky record that the interrupt line was seen high.
    always @(posedge CLK_SYS) begin
        if (!RESET_N) IRQ_SEEN <= 1'b0;
        else if (EVENT_IRQ) IRQ_SEEN <= 1'b1;
    end
endmodule // pwm_irq_sink
`default_nettype wire

/* File: src/pwm_counter_compare_events.v */
// Notes on behaviour
// - Raw status latches every event regardless of mask.
// - Status bits: zero, limit, firstUp/Down, secondUp/Down.
// - Masked status shows only enabled latched events.
// - Writing one to masked status clears event.
// - Limit is 16-bit read/write, resets zero.
// - Count-down reloads limit after reaching zero.
// - Up/down counts to limit, then back down.
// - Immediate mode: new limit applies at zero.
// - Sync mode: limit applies at zero after request.
// - Rewriting pending value keeps only newest.
// - Counter value readable, 16-bit, resets zero.
// - Counter equal limit emits one-cycle pulse.
// - Counter equal zero emits one-cycle pulse.
// - Counter equal compare emits compare pulse.
// - Compare above limit never pulses.
// - Compare values 16-bit read/write, reset zero.
// - First compare uses its own update mode.
// - Second compare uses its own update mode.
// - Each event has enable; masked = raw and enable.
// - Mode zero counts down, one counts up/down.
// - Update bit zero immediate, one synchronous.
`include "pwm_counter_regs.vh"
`default_nettype none
module pwm_counter_compare_events #(
    parameter CW = 16
) (
    // Clock and reset.
    input wire CLK_SYS,
    input wire RESET_N,
    // APB slave.
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output reg PREADY,
    output reg PSLVERR,
    // Event pulses and direction level to output action logic.
    output reg ZERO_PULSE,
    output reg LIMIT_PULSE,
    output reg FIRST_MATCH_PULSE,
    output reg SECOND_MATCH_PULSE,
    output reg COUNT_DIR_UP,
    // Masked event summary to the interrupt controller.
    output reg EVENT_IRQ
);
    reg [`CTL_WIDTH-1:0] control_reg;
    reg [`EV_WIDTH-1:0] enable_mask_reg;
    reg [`EV_WIDTH-1:0] raw_status_reg;
    reg [CW-1:0] limit_pend_reg;
    reg [CW-1:0] limit_act_reg;
    reg [CW-1:0] first_pend_reg;
    reg [CW-1:0] first_act_reg;
    reg [CW-1:0] second_pend_reg;
    reg [CW-1:0] second_act_reg;
    reg [2:0] sync_req_reg;
    reg [CW-1:0] count_reg;
    reg dir_up_reg;
    reg [CW-1:0] count_next;
    reg dir_up_next;
    reg [`EV_WIDTH-1:0] events;
    reg [31:0] rdata_next;
    reg [2:0] sync_req_next;
    reg [`EV_WIDTH-1:0] raw_next;
    wire wr;
    wire rd;
    wire at_zero;
    wire addr_ok;
    wire [`EV_WIDTH-1:0] masked_status;

    // Compare pulse: value must lie within the active limit.
    function cmp_hit;
        input [CW-1:0] cnt;
        input [CW-1:0] cmp;
        input [CW-1:0] lim;
        begin
            cmp_hit = (cnt == cmp) && (cmp <= lim);
        end
    endfunction

    assign wr = PSEL && PENABLE && PWRITE;
    assign rd = PSEL && !PWRITE;
    assign at_zero = (count_reg == `VAL_RESET);
    assign masked_status = raw_status_reg & enable_mask_reg;
    assign addr_ok = (PADDR == `ADDR_CONTROL) || (PADDR == `ADDR_ENABLE_MASK) ||
        (PADDR == `ADDR_RAW_STATUS) || (PADDR == `ADDR_MASKED_STATUS) ||
        (PADDR == `ADDR_LIMIT) || (PADDR == `ADDR_COUNT) ||
        (PADDR == `ADDR_CMP_FIRST) || (PADDR == `ADDR_CMP_SECOND) ||
        (PADDR == `ADDR_SYNC_REQ);

    // Counter step.
    always @* begin
        count_next = count_reg;
        dir_up_next = dir_up_reg;
        if (!control_reg[`CTL_MODE]) begin
            dir_up_next = 1'b0;
            if (at_zero) begin
                count_next = limit_act_reg;
            end else begin
                count_next = count_reg - 1'b1;
            end
        end else begin
            if (at_zero) begin
                if (limit_act_reg == `VAL_RESET) begin
                    dir_up_next = 1'b0;
                end else begin
                    dir_up_next = 1'b1;
                    count_next = count_reg + 1'b1;
                end
            end else if (dir_up_reg && count_reg < limit_act_reg) begin
                count_next = count_reg + 1'b1;
            end else begin
                dir_up_next = 1'b0;
                count_next = count_reg - 1'b1;
            end
        end
    end

    // Events seen this cycle, by bit position.
    always @* begin
        events = {`EV_WIDTH{1'b0}};
        events[`EV_ZERO] = at_zero;
        events[`EV_LIMIT] = (count_reg == limit_act_reg);
        events[`EV_FIRST_UP] = control_reg[`CTL_MODE] && dir_up_reg &&
            cmp_hit(count_reg, first_act_reg, limit_act_reg);
        events[`EV_FIRST_DOWN] = !(control_reg[`CTL_MODE] && dir_up_reg) &&
            cmp_hit(count_reg, first_act_reg, limit_act_reg);
        events[`EV_SECOND_UP] = control_reg[`CTL_MODE] && dir_up_reg &&
            cmp_hit(count_reg, second_act_reg, limit_act_reg);
        events[`EV_SECOND_DOWN] = !(control_reg[`CTL_MODE] && dir_up_reg) &&
            cmp_hit(count_reg, second_act_reg, limit_act_reg);
    end

    // Raw status: events set, W1C clears, set wins.
    always @* begin
        raw_next = raw_status_reg;
        if (wr && PADDR == `ADDR_MASKED_STATUS) begin
            raw_next = raw_next & ~PWDATA[`EV_WIDTH-1:0];
        end
        raw_next = raw_next | events;
    end

    // Sync requests: held until the next zero consumes them.
    always @* begin
        sync_req_next = sync_req_reg;
        if (at_zero) begin
            sync_req_next = 3'h0;
        end
        if (wr && PADDR == `ADDR_SYNC_REQ) begin
            sync_req_next = sync_req_next | PWDATA[2:0];
        end
    end

    // Read mux.
    always @* begin
        rdata_next = 32'h00000000;
        case (PADDR)
            `ADDR_CONTROL: rdata_next[`CTL_WIDTH-1:0] = control_reg;
            `ADDR_ENABLE_MASK: rdata_next[`EV_WIDTH-1:0] = enable_mask_reg;
            `ADDR_RAW_STATUS: rdata_next[`EV_WIDTH-1:0] = raw_status_reg;
            `ADDR_MASKED_STATUS: rdata_next[`EV_WIDTH-1:0] = masked_status;
            `ADDR_LIMIT: rdata_next[CW-1:0] = limit_pend_reg;
            `ADDR_COUNT: rdata_next[CW-1:0] = count_reg;
            `ADDR_CMP_FIRST: rdata_next[CW-1:0] = first_pend_reg;
            `ADDR_CMP_SECOND: rdata_next[CW-1:0] = second_pend_reg;
            `ADDR_SYNC_REQ: rdata_next[2:0] = sync_req_reg;
            default: rdata_next = 32'h00000000;
        endcase
    end

    // Write strobes for the control, mask, limit and compare registers, taken in the access phase.
    wire wr_control;
    wire wr_mask;
    wire wr_limit;
    wire wr_first;
    wire wr_second;
    // Transfer of a pending value into its active copy.
    wire take_limit;
    wire take_first;
    wire take_second;

    // An active copy changes only while the counter sits at zero, so a
    // period never sees a limit or compare value change halfway through.
    function take_now;
        input upd_sync;
        input req;
        begin
            take_now = at_zero && (!upd_sync || req);
        end
    endfunction

    assign wr_control = wr && (PADDR == `ADDR_CONTROL);
    assign wr_mask = wr && (PADDR == `ADDR_ENABLE_MASK);
    assign wr_limit = wr && (PADDR == `ADDR_LIMIT);
    assign wr_first = wr && (PADDR == `ADDR_CMP_FIRST);
    assign wr_second = wr && (PADDR == `ADDR_CMP_SECOND);
    assign take_limit = take_now(control_reg[`CTL_LIMIT_UPD], sync_req_reg[`SYNC_LIMIT]);
    assign take_first = take_now(control_reg[`CTL_FIRST_UPD], sync_req_reg[`SYNC_FIRST]);
    assign take_second = take_now(control_reg[`CTL_SECOND_UPD], sync_req_reg[`SYNC_SECOND]);

    // Control bits: counting mode and the three update modes.
    always @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            control_reg <= {`CTL_WIDTH{1'b0}};
        end else if (wr_control) begin
            control_reg <= PWDATA[`CTL_WIDTH-1:0];
        end
    end

    // Per-event enables toward the interrupt controller.
    always @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            enable_mask_reg <= {`EV_WIDTH{1'b0}};
        end else if (wr_mask) begin
            enable_mask_reg <= PWDATA[`EV_WIDTH-1:0];
        end
    end

    // Pending limit: a rewrite before the transfer simply replaces it.
    always @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            limit_pend_reg <= `VAL_RESET;
        end else if (wr_limit) begin
            limit_pend_reg <= PWDATA[CW-1:0];
        end
    end

    // Pending first compare value.
    always @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            first_pend_reg <= `VAL_RESET;
        end else if (wr_first) begin
            first_pend_reg <= PWDATA[CW-1:0];
        end
    end

    // Pending second compare value.
    always @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            second_pend_reg <= `VAL_RESET;
        end else if (wr_second) begin
            second_pend_reg <= PWDATA[CW-1:0];
        end
    end

    // Active limit, used by the counter and the comparators.
    always @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            limit_act_reg <= `VAL_RESET;
        end else if (take_limit) begin
            limit_act_reg <= limit_pend_reg;
        end
    end

    // Active first compare value.
    always @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            first_act_reg <= `VAL_RESET;
        end else if (take_first) begin
            first_act_reg <= first_pend_reg;
        end
    end

    // Active second compare value.
    always @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            second_act_reg <= `VAL_RESET;
        end else if (take_second) begin
            second_act_reg <= second_pend_reg;
        end
    end

    // Counter and direction run on every clock.
    always @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            count_reg <= `VAL_RESET;
            dir_up_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            dir_up_reg <= dir_up_next;
        end
    end

    // Latched events; an event in the same cycle as its clear stays set,
    // so software never loses an event that it has not yet seen.
    always @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            raw_status_reg <= {`EV_WIDTH{1'b0}};
        end else begin
            raw_status_reg <= raw_next;
        end
    end

    // Synchronous update requests, held until the next counter zero.
    always @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            sync_req_reg <= 3'h0;
        end else begin
            sync_req_reg <= sync_req_next;
        end
    end

    // No wait state: ready rises in the first access cycle and stands
    // one clock; the error flag rides with it for unmapped addresses.
    always @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
        end else begin
            PREADY <= PSEL && !PREADY;
            PSLVERR <= PSEL && !PREADY && !addr_ok;
        end
    end

    // Read data is captured while the address stands, ready for the ready cycle.
    always @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            PRDATA <= 32'h00000000;
        end else if (rd) begin
            PRDATA <= rdata_next;
        end
    end

    // Zero and limit pulses, one clock behind the counter state.
    always @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            ZERO_PULSE <= 1'b0;
            LIMIT_PULSE <= 1'b0;
        end else begin
            ZERO_PULSE <= events[`EV_ZERO];
            LIMIT_PULSE <= events[`EV_LIMIT];
        end
    end

    // Compare pulses merge both directions of each comparator.
    always @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            FIRST_MATCH_PULSE <= 1'b0;
            SECOND_MATCH_PULSE <= 1'b0;
        end else begin
            FIRST_MATCH_PULSE <= events[`EV_FIRST_UP] | events[`EV_FIRST_DOWN];
            SECOND_MATCH_PULSE <= events[`EV_SECOND_UP] | events[`EV_SECOND_DOWN];
        end
    end

    // Direction level for the output action logic.
    always @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            COUNT_DIR_UP <= 1'b0;
        end else begin
            COUNT_DIR_UP <= dir_up_reg;
        end
    end

    // Interrupt line follows the next latched state, so a clear drops it
    // in the same clock in which the status bit goes.
    always @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            EVENT_IRQ <= 1'b0;
        end else begin
            EVENT_IRQ <= |(raw_next & enable_mask_reg);
        end
    end
endmodule // pwm_counter_compare_events
`default_nettype wire

/* File: src/pwm_counter_regs.vh */
`ifndef PWM_COUNTER_REGS_VH
`define PWM_COUNTER_REGS_VH
// Register byte addresses.
`define ADDR_CONTROL 12'h040
`define ADDR_ENABLE_MASK 12'h044
`define ADDR_RAW_STATUS 12'h048
`define ADDR_MASKED_STATUS 12'h04C
`define ADDR_LIMIT 12'h050
`define ADDR_COUNT 12'h054
`define ADDR_CMP_FIRST 12'h058
`define ADDR_CMP_SECOND 12'h05C
`define ADDR_SYNC_REQ 12'h000
// Control register fields.
`define CTL_MODE 1
`define CTL_LIMIT_UPD 3
`define CTL_FIRST_UPD 4
`define CTL_SECOND_UPD 5
`define CTL_WIDTH 6
// Event bit positions.
`define EV_ZERO 0
`define EV_LIMIT 1
`define EV_FIRST_UP 2
`define EV_FIRST_DOWN 3
`define EV_SECOND_UP 4
`define EV_SECOND_DOWN 5
`define EV_WIDTH 6
// Sync request register fields.
`define SYNC_LIMIT 0
`define SYNC_FIRST 1
`define SYNC_SECOND 2
`define VAL_RESET 16'h0000
`endif
